/* File: tis_pkg.sv */
`default_nettype none
// ==========================================================================
// shared constants of the touch register slave
// ==========================================================================
package tis_pkg;

  // slave address pairs, write and read form
  localparam logic [7:0]  ADDR_MAIN_WR     = 8'hba;
  localparam logic [7:0]  ADDR_MAIN_RD     = 8'hbb;
  localparam logic [7:0]  ADDR_ALT_WR      = 8'h28;
  localparam logic [7:0]  ADDR_ALT_RD      = 8'h29;

  // register offsets
  localparam logic [15:0] REG_STATUS       = 16'h814e;
  localparam logic [15:0] REG_TRACK_ID     = 16'h814f;
  localparam logic [15:0] REG_X_LOW        = 16'h8150;
  localparam logic [15:0] REG_X_HIGH       = 16'h8151;
  localparam logic [15:0] REG_Y_LOW        = 16'h8152;
  localparam logic [15:0] REG_Y_HIGH       = 16'h8153;
  localparam logic [15:0] REG_SIZE_LOW     = 16'h8154;
  localparam logic [15:0] REG_SIZE_HIGH    = 16'h8155;
  localparam logic [15:0] REG_RSVD_AFTER   = 16'h8156;

  // status field layout
  localparam int          STAT_READY_BIT   = 7;
  localparam int          STAT_LARGE_BIT   = 6;
  localparam int          STAT_COUNT_W     = 4;

  // reset values
  localparam logic [7:0]  STATUS_RST       = 8'h00;
  localparam logic [15:0] POINTER_RST      = 16'h0000;
  localparam logic [7:0]  DATA_RST         = 8'h00;

  // bit counts of one unit on the wire
  localparam logic [3:0]  LAST_DATA_BIT    = 4'h7;
  localparam logic [3:0]  ACK_BIT          = 4'h8;

  // transfer phases, one-hot
  typedef enum logic [5:0] {
    TIS_IDLE    = 6'h01,
    TIS_DEVADDR = 6'h02,
    TIS_PTR_HI  = 6'h04,
    TIS_PTR_LO  = 6'h08,
    TIS_WRITE   = 6'h10,
    TIS_READ    = 6'h20
  } tis_state_t;

endpackage : tis_pkg
`default_nettype wire

/* File: tis_bit_capture.sv */
`default_nettype none
// ==========================================================================
// serial clock domain: samples data on each rising bus clock edge
// ==========================================================================
module tis_bit_capture (
  input  wire logic       touch_serial_clock,
  input  wire logic       rst,
  input  wire logic       sda_in,
  output logic [7:0]      shift_byte,
  output logic            bit_toggle
);

  typedef struct packed {
    logic [7:0] sh;
    logic       tog;
  } tis_cap_t;

  tis_cap_t cap_reg;
  tis_cap_t cap_next;

  // shift in one bit and flip the event toggle
  always_comb begin
    cap_next     = cap_reg;
    cap_next.sh  = {cap_reg.sh[6:0], sda_in};
    cap_next.tog = ~cap_reg.tog;
  end

  // word stays stable a whole bus clock period after each toggle
  always_ff @(posedge touch_serial_clock or posedge rst) begin
    if (rst) begin
      cap_reg <= '0;
    end else begin
      cap_reg <= cap_next;
    end
  end

  assign shift_byte = cap_reg.sh;
  assign bit_toggle = cap_reg.tog;

endmodule : tis_bit_capture
`default_nettype wire

/* File: tis_register_slave.sv */
// What this block does
// - answer either address pair: 0xba/0xbb or 0x28/0x29
// - host picks the pair via reset and interrupt levels; device latches it
// - data falling while clock high is start; data rising is stop
// - matching address byte gets a low acknowledge on the ninth clock
// - non-matching address: stay idle, no acknowledge, no part taken
// - each unit is eight data bits plus one acknowledge bit
// - data changes only while clock is low, except start and stop
// - pointer advances by one after each written data byte
// - reads run on through registers until master not-acknowledges, then stop
// - supports bus rates up to 400 kbit/s
// - status bit 7 is one when touch data is ready, else zero
// - status bit 6 is one during a large-area touch
// - status low field holds touch point count; bits between are reserved
// - track id at 0x814f, x low/high at 0x8150/0x8151, read-only
// - y low/high at 0x8152/0x8153, read-only
// - size low/high at 0x8154/0x8155, reserved register at 0x8156
// - active-low interrupt output asks the host for a transfer
// - active-low external reset input holds the controller in reset
`default_nettype none
module tis_register_slave (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        touch_serial_clock,
  input  wire logic        touch_serial_data_in,
  output logic             touch_serial_data_out,
  output logic             touch_serial_data_oe,
  input  wire logic        touch_irq_in,
  output logic             touch_irq_out,
  output logic             touch_irq_oe,
  input  wire logic        touch_reset_n,
  input  wire logic        point_update,
  input  wire logic [3:0]  point_count,
  input  wire logic        point_large,
  input  wire logic [7:0]  point_track_id,
  input  wire logic [15:0] point_x,
  input  wire logic [15:0] point_y,
  input  wire logic [15:0] point_size,
  output logic             alt_address_sel,
  output logic             data_ready,
  output logic             bus_busy
);

  // ========================================================================
  // state
  // ========================================================================
  typedef struct packed {
    tis_pkg::tis_state_t st;
    logic [3:0]          cnt;       // bits seen in the current unit
    logic [15:0]         ptr;       // register pointer
    logic [7:0]          txb;       // byte being sent on a read
    logic                ack_en;    // acknowledge owed on the ninth clock
    logic                drive;     // pulling data low
    logic                strap_alt; // latched address pair choice
    logic                stat_ready;
    logic                stat_large;
    logic [3:0]          stat_count;
    logic [7:0]          track;
    logic [15:0]         x;
    logic [15:0]         y;
    logic [15:0]         size;
    logic                scl_m;
    logic                scl_s;
    logic                scl_p;
    logic                sda_m;
    logic                sda_s;
    logic                sda_p;
    logic                rn_m;
    logic                rn_s;
    logic                rn_p;
    logic                irq_m;
    logic                irq_s;
    logic                tog_m;
    logic                tog_s;
    logic                tog_p;
  } tis_state_s_t;

  tis_state_s_t q_reg;
  tis_state_s_t q_next;

  logic [7:0] cap_byte;
  logic       cap_tog;

  // ========================================================================
  // bus clock domain capture
  // ========================================================================
  tis_bit_capture u_capture (
    .touch_serial_clock (touch_serial_clock),
    .rst                (rst),
    .sda_in             (touch_serial_data_in),
    .shift_byte         (cap_byte),
    .bit_toggle         (cap_tog)
  );

  // ========================================================================
  // helpers
  // ========================================================================

  // register file read view
  // unmapped and reserved offsets read as zero
  function automatic logic [7:0] tis_read_byte(
    input logic [15:0]  a,
    input tis_state_s_t r
  );
    logic [7:0] v;
    v = tis_pkg::DATA_RST;
    case (a)
      tis_pkg::REG_STATUS: begin
        v[tis_pkg::STAT_READY_BIT] = r.stat_ready;
        v[tis_pkg::STAT_LARGE_BIT] = r.stat_large;
        v[tis_pkg::STAT_COUNT_W-1:0] = r.stat_count;
      end
      tis_pkg::REG_TRACK_ID:   v = r.track;
      tis_pkg::REG_X_LOW:      v = r.x[7:0];
      tis_pkg::REG_X_HIGH:     v = r.x[15:8];
      tis_pkg::REG_Y_LOW:      v = r.y[7:0];
      tis_pkg::REG_Y_HIGH:     v = r.y[15:8];
      tis_pkg::REG_SIZE_LOW:   v = r.size[7:0];
      tis_pkg::REG_SIZE_HIGH:  v = r.size[15:8];
      tis_pkg::REG_RSVD_AFTER: v = tis_pkg::DATA_RST;
      default:                 v = tis_pkg::DATA_RST;
    endcase
    return v;
  endfunction : tis_read_byte

  // address byte compare against the latched pair
  function automatic logic tis_match(
    input logic [7:0] b,
    input logic       alt,
    input logic       rd
  );
    logic [7:0] w;
    logic [7:0] r;
    w = alt ? tis_pkg::ADDR_ALT_WR : tis_pkg::ADDR_MAIN_WR;
    r = alt ? tis_pkg::ADDR_ALT_RD : tis_pkg::ADDR_MAIN_RD;
    return rd ? (b == r) : (b == w);
  endfunction : tis_match

  // ========================================================================
  // bus events seen from the system clock
  // ========================================================================
  logic start_seen;
  logic stop_seen;
  logic bit_seen;
  logic scl_fall;

  // start and stop only count while the clock stays high
  assign start_seen = q_reg.scl_s & q_reg.scl_p & q_reg.sda_p & ~q_reg.sda_s;
  assign stop_seen  = q_reg.scl_s & q_reg.scl_p & ~q_reg.sda_p & q_reg.sda_s;
  // the captured byte is read only while bit_seen is high: the toggle has then
  // crossed two flops and the byte stands for a whole bus clock period
  assign bit_seen   = q_reg.tog_s ^ q_reg.tog_p;
  assign scl_fall   = q_reg.scl_p & ~q_reg.scl_s;

  // ========================================================================
  // next state
  // ========================================================================
  always_comb begin
    q_next = q_reg;

    // two-stage synchronisers; 100 MHz sampling is ample for 400 kbit/s
    q_next.scl_m = touch_serial_clock;
    q_next.scl_s = q_reg.scl_m;
    q_next.scl_p = q_reg.scl_s;
    q_next.sda_m = touch_serial_data_in;
    q_next.sda_s = q_reg.sda_m;
    q_next.sda_p = q_reg.sda_s;
    q_next.rn_m  = touch_reset_n;
    q_next.rn_s  = q_reg.rn_m;
    q_next.rn_p  = q_reg.rn_s;
    q_next.irq_m = touch_irq_in;
    q_next.irq_s = q_reg.irq_m;
    q_next.tog_m = cap_tog;
    q_next.tog_s = q_reg.tog_m;
    q_next.tog_p = q_reg.tog_s;

    // latch the address pair at reset release from the interrupt level
    // a mid-run external reset takes the strap again, so the pair may change
    if (q_reg.rn_s && !q_reg.rn_p) begin
      q_next.strap_alt = q_reg.irq_s;
    end

    if (!q_reg.rn_s) begin
      // external reset holds bus state and status; strap, track, x, y and size keep their values           
      q_next.st         = tis_pkg::TIS_IDLE;
      q_next.cnt        = 4'h0;
      q_next.ptr        = tis_pkg::POINTER_RST;
      q_next.ack_en     = 1'b0;
      q_next.drive      = 1'b0;
      q_next.stat_ready = 1'b0;
      q_next.stat_large = 1'b0;
      q_next.stat_count = 4'h0;
    end else if (start_seen) begin
      // start or repeated start: expect an address byte         
      q_next.st     = tis_pkg::TIS_DEVADDR;
      q_next.cnt    = 4'h0;
      q_next.ack_en = 1'b0;
      q_next.drive  = 1'b0;
    end else if (stop_seen) begin
      q_next.st     = tis_pkg::TIS_IDLE;
      q_next.cnt    = 4'h0;
      q_next.ack_en = 1'b0;
      q_next.drive  = 1'b0;
    end else if (bit_seen && q_reg.st != tis_pkg::TIS_IDLE) begin
      if (q_reg.cnt == tis_pkg::ACK_BIT) begin
        // ninth bit of the unit closes it                       
        q_next.cnt    = 4'h0;
        q_next.ack_en = 1'b0;
        if (q_reg.st == tis_pkg::TIS_READ) begin
          if (q_reg.ack_en) begin
            // this ninth bit was our own read address acknowledge, not the
            // master's: the first byte comes from the pointer as it stands
            q_next.ptr = q_reg.ptr;
          end else if (cap_byte[0]) begin
            // master not-acknowledge: last byte, wait for stop
            q_next.st = tis_pkg::TIS_IDLE;
          end else begin
            q_next.ptr = q_reg.ptr + 16'h0001;
            q_next.txb = tis_read_byte(q_reg.ptr + 16'h0001, q_reg);
          end
        end
      end else begin
        q_next.cnt = q_reg.cnt + 4'h1;
        if (q_reg.cnt == tis_pkg::LAST_DATA_BIT) begin
          // eighth bit: a full byte is in the capture register
          case (q_reg.st)
            tis_pkg::TIS_DEVADDR: begin
              if (tis_match(cap_byte, q_reg.strap_alt, 1'b0)) begin
                q_next.st     = tis_pkg::TIS_PTR_HI;
                q_next.ack_en = 1'b1;
              end else if (tis_match(cap_byte, q_reg.strap_alt, 1'b1)) begin
                q_next.st     = tis_pkg::TIS_READ;
                q_next.ack_en = 1'b1;
                q_next.txb    = tis_read_byte(q_reg.ptr, q_reg);
              end else begin
                q_next.st     = tis_pkg::TIS_IDLE;
              end
            end
            tis_pkg::TIS_PTR_HI: begin
              q_next.ptr[15:8] = cap_byte;
              q_next.st        = tis_pkg::TIS_PTR_LO;
              q_next.ack_en    = 1'b1;
            end
            tis_pkg::TIS_PTR_LO: begin
              q_next.ptr[7:0] = cap_byte;
              q_next.st       = tis_pkg::TIS_WRITE;
              q_next.ack_en   = 1'b1;
            end
            tis_pkg::TIS_WRITE: begin
              // only status takes writes; others ignored but acknowledged
              if (q_reg.ptr == tis_pkg::REG_STATUS) begin
                q_next.stat_ready = cap_byte[tis_pkg::STAT_READY_BIT];
                q_next.stat_large = cap_byte[tis_pkg::STAT_LARGE_BIT];
                q_next.stat_count = cap_byte[tis_pkg::STAT_COUNT_W-1:0];
              end
              q_next.ptr    = q_reg.ptr + 16'h0001;
              q_next.ack_en = 1'b1;
            end
            tis_pkg::TIS_READ: begin
              q_next.ack_en = 1'b0;
            end
            default: begin
              q_next.st = tis_pkg::TIS_IDLE;
            end
          endcase
        end
      end
    end

    // data pin changes only after the bus clock has fallen
    // a start or stop releases the pin at once, whatever was owed
    if (start_seen || stop_seen || !q_reg.rn_s) begin
      q_next.drive = 1'b0;
    end else if (scl_fall) begin
      if (q_reg.cnt == tis_pkg::ACK_BIT) begin
        q_next.drive = q_reg.ack_en;
      end else if (q_reg.st == tis_pkg::TIS_READ) begin
        q_next.drive = ~q_reg.txb[3'd7 - q_reg.cnt[2:0]];
      end else begin
        q_next.drive = 1'b0;
      end
    end

    // fresh touch data; the set wins over a host clear this cycle
    // point data is dropped while the external reset is held
    if (point_update && q_reg.rn_s) begin
      q_next.stat_ready = 1'b1;
      q_next.stat_large = point_large;
      q_next.stat_count = point_count;
      q_next.track      = point_track_id;
      q_next.x          = point_x;
      q_next.y          = point_y;
      q_next.size       = point_size;
    end
  end

  // ========================================================================
  // registers
  // ========================================================================
  // bus pins reset to their idle high level so no false start or stop follows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_reg            <= '0;
      q_reg.st         <= tis_pkg::TIS_IDLE;
      q_reg.ptr        <= tis_pkg::POINTER_RST;
      q_reg.stat_ready <= tis_pkg::STATUS_RST[tis_pkg::STAT_READY_BIT];
      q_reg.scl_m      <= 1'b1;
      q_reg.scl_s      <= 1'b1;
      q_reg.scl_p      <= 1'b1;
      q_reg.sda_m      <= 1'b1;
      q_reg.sda_s      <= 1'b1;
      q_reg.sda_p      <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  // ========================================================================
  // outputs
  // ========================================================================

  // open-drain data pin: enable means pulling low; never starts a transfer
  assign touch_serial_data_out = 1'b0;
  assign touch_serial_data_oe  = q_reg.drive;

  // interrupt held low while data waits, not during reset or strapping
  assign touch_irq_out = 1'b0;
  assign touch_irq_oe  = q_reg.stat_ready & q_reg.rn_s & q_reg.rn_p;

  // status towards the local side
  // busy rises on every start while the external reset is released; a non-matching address byte drops it after its eighth bit
  assign alt_address_sel = q_reg.strap_alt;
  assign data_ready      = q_reg.stat_ready;
  assign bus_busy        = (q_reg.st != tis_pkg::TIS_IDLE);

endmodule : tis_register_slave
`default_nettype wire

/* File: tis_register_slave_properties.sv */
`default_nettype none
// ==========================================================================
// temporal checks on the touch register slave ports
// ==========================================================================
module tis_register_slave_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        touch_serial_clock,
  input wire logic        touch_serial_data_in,
  input wire logic        touch_serial_data_out,
  input wire logic        touch_serial_data_oe,
  input wire logic        touch_irq_in,
  input wire logic        touch_irq_out,
  input wire logic        touch_irq_oe,
  input wire logic        touch_reset_n,
  input wire logic        point_update,
  input wire logic        alt_address_sel,
  input wire logic        data_ready,
  input wire logic        bus_busy
);
  logic [3:0] rn_cnt_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // cycles since the external reset went high, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rn_cnt_reg <= 4'h0;
    end else if (!touch_reset_n) begin
      rn_cnt_reg <= 4'h0;
    end else if (rn_cnt_reg != 4'hf) begin
      rn_cnt_reg <= rn_cnt_reg + 4'h1;
    end
  end

  // stop seen on the pins: data rises while clock high
  sequence seq_stop;
    touch_serial_clock && $rose(touch_serial_data_in);
  endsequence
  // point data taken once the reset synchroniser has settled
  sequence seq_update;
    point_update && (rn_cnt_reg == 4'hf);
  endsequence

  AST_SDA_OUT_LOW: assert property (touch_serial_data_out == 1'b0)
    else $error("data pin output value is not low");
  AST_IRQ_OUT_LOW: assert property (touch_irq_out == 1'b0)
    else $error("interrupt pin output value is not low");
  AST_UPDATE_READY: assert property (seq_update |=> data_ready && touch_irq_oe)
    else $error("point update did not raise ready and interrupt");
  AST_IRQ_TRACKS: assert property ((rn_cnt_reg == 4'hf) |-> touch_irq_oe == data_ready)
    else $error("interrupt request differs from ready flag");
  AST_RESET_QUIET: assert property ((!touch_reset_n) [*7] |->
      !data_ready && !bus_busy && !touch_serial_data_oe)
    else $error("activity while external reset held low");
  AST_OE_SCL_LOW: assert property ($changed(touch_serial_data_oe) |-> !touch_serial_clock)
    else $error("data drive changed while bus clock high");
  AST_ACK_HOLDS: assert property ($rose(touch_serial_data_oe) |=> touch_serial_data_oe [*8])
    else $error("data drive released too early");
  AST_STOP_IDLE: assert property (seq_stop |-> ##[1:8] !bus_busy)
    else $error("busy still high after stop");
  AST_ALT_STRAP: assert property ($changed(alt_address_sel) |-> rn_cnt_reg < 4'ha)
    else $error("address pair changed outside reset release");
endmodule : tis_register_slave_checker

bind tis_register_slave tis_register_slave_checker chk (
  .clk(clk), .rst(rst), .touch_serial_clock(touch_serial_clock),
  .touch_serial_data_in(touch_serial_data_in), .touch_serial_data_out(touch_serial_data_out),
  .touch_serial_data_oe(touch_serial_data_oe), .touch_irq_in(touch_irq_in),
  .touch_irq_out(touch_irq_out), .touch_irq_oe(touch_irq_oe), .touch_reset_n(touch_reset_n),
  .point_update(point_update), .alt_address_sel(alt_address_sel),
  .data_ready(data_ready), .bus_busy(bus_busy)
);
`default_nettype wire

/* File: tis_host_model.sv */
`default_nettype none
// ==========================================================================
// host bus master model: makes the bus clock, pulls data low
// ==========================================================================
module tis_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time Q = 72ns; // quarter bit, six link clock steps of 12 ns

  // bus idles with clock standing high and data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // start or repeated start, only ever issued by this master
  task automatic start();
    sda_low = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_low = 1'b1;
    #Q;
    scl = 1'b0;
  endtask : start

  // one bit: data set while clock low, sampled while high
  task automatic bit_io(input logic o, output logic i);
    #Q;
    sda_low = !o;
    #Q;
    scl = 1'b1;
    #Q;
    i = sda;
    #Q;
    scl = 1'b0;
  endtask : bit_io

  // byte msb first, then the acknowledge bit (ack_o high releases)
  task automatic xfer(input logic [7:0] o, input logic ack_o,
                      output logic [7:0] i, output logic ack_i);
    for (int k = 7; k >= 0; k--) begin
      bit_io(o[k], i[k]);
    end
    bit_io(ack_o, ack_i);
  endtask : xfer

  // stop: data rises while clock high, then clock stands still
  task automatic stop();
    #Q;
    sda_low = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_low = 1'b0;
    #(4 * Q);
  endtask : stop
endmodule : tis_host_model
`default_nettype wire

/* File: tb.sv */
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
// ==========================================================================
// bench: host transfers against the touch register slave
// ==========================================================================
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0]  CNT = 4'h2;
  localparam logic [7:0]  TRK = 8'h05;
  localparam logic [15:0] PX  = 16'h1234;
  localparam logic [15:0] PY  = 16'h0abc;
  localparam logic [15:0] PS  = 16'h0140;
  localparam logic [7:0]  RD_EXP [9] = '{{2'b11, 2'b00, CNT}, TRK, PX[7:0], PX[15:8],
                                        PY[7:0], PY[15:8], PS[7:0], PS[15:8], 8'h00};
  logic        clk, rst, touch_reset_n, strap_low, point_update, point_large;
  logic [3:0]  point_count;
  logic [7:0]  point_track_id;
  logic [15:0] point_x, point_y, point_size;
  wire logic   scl, sda_low, sda_oe, sda_out, irq_oe, irq_out, alt, rdy, busy, sda_w, irq_w;
  int          bad_count, checked;

  // open-drain wires with pull-ups
  assign sda_w = !(sda_oe || sda_low);
  assign irq_w = !(irq_oe || strap_low);

  tis_register_slave dut (
    .clk(clk), .rst(rst), .touch_serial_clock(scl), .touch_serial_data_in(sda_w),
    .touch_serial_data_out(sda_out), .touch_serial_data_oe(sda_oe), .touch_irq_in(irq_w),
    .touch_irq_out(irq_out), .touch_irq_oe(irq_oe), .touch_reset_n(touch_reset_n),
    .point_update(point_update), .point_count(point_count), .point_large(point_large),
    .point_track_id(point_track_id), .point_x(point_x), .point_y(point_y),
    .point_size(point_size), .alt_address_sel(alt), .data_ready(rdy), .bus_busy(busy)
  );
  tis_host_model host (.scl(scl), .sda_low(sda_low), .sda(sda_w));

  // system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    conclude();
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic send(input logic [7:0] b, input logic ack_exp);
    logic [7:0] i;
    logic       a;
    host.xfer(b, 1'b1, i, a);
    `CHK("acknowledge", ack_exp, a)
  endtask : send

  task automatic recv(input logic [7:0] exp, input logic last);
    logic [7:0] i;
    logic       a;
    host.xfer(8'hff, last, i, a);
    `CHK("read data", exp, i)
  endtask : recv

  // external reset pulse with the interrupt wire as address strap
  task automatic strap(input logic alt_exp);
    touch_reset_n = 1'b0;
    strap_low = !alt_exp;
    repeat (8) @(negedge clk);
    touch_reset_n = 1'b1;
    repeat (8) @(negedge clk);
    strap_low = 1'b0;
    repeat (8) @(negedge clk);
    `CHK("address pair", alt_exp, alt)
  endtask : strap

  // main sequence
  initial begin
    rst = 1'b1;
    touch_reset_n = 1'b0;
    strap_low = 1'b1;
    point_update = 1'b0;
    point_large = 1'b0;
    point_count = 4'h0;
    point_track_id = 8'h00;
    point_x = 16'h0000;
    point_y = 16'h0000;
    point_size = 16'h0000;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    strap(1'b0);
    `CHK("ready after reset", 1'b0, rdy)
    point_count = CNT;
    point_large = 1'b1;
    point_track_id = TRK;
    point_x = PX;
    point_y = PY;
    point_size = PS;
    point_update = 1'b1;
    @(negedge clk);
    point_update = 1'b0;
    `CHK("ready", 1'b1, rdy)
    `CHK("interrupt", 1'b1, irq_oe)
    host.start();
    send(8'h28, 1'b1);
    `CHK("busy on foreign address", 1'b0, busy)
    host.stop();
    `CHK("busy", 1'b0, busy)
    host.start();
    send(8'hba, 1'b0);
    send(8'h81, 1'b0);
    send(8'h4e, 1'b0);
    host.start();
    send(8'hbb, 1'b0);
    for (int k = 0; k < 9; k++) begin
      recv(RD_EXP[k], k == 8);
    end
    host.stop();
    host.start();
    send(8'hba, 1'b0);
    send(8'h81, 1'b0);
    send(8'h4e, 1'b0);
    send(8'h00, 1'b0);
    send(8'hff, 1'b0);
    host.stop();
    `CHK("ready cleared", 1'b0, rdy)
    `CHK("interrupt cleared", 1'b0, irq_oe)
    host.start();
    send(8'hbb, 1'b0);
    recv(PX[7:0], 1'b0);
    recv(PX[15:8], 1'b1);
    host.stop();
    host.start();
    send(8'hba, 1'b0);
    send(8'h81, 1'b0);
    send(8'h4e, 1'b0);
    host.start();
    send(8'hbb, 1'b0);
    recv(8'h00, 1'b0);
    recv(TRK, 1'b1);
    host.stop();
    @(negedge clk);
    point_update = 1'b1;
    @(negedge clk);
    point_update = 1'b0;
    `CHK("ready before external reset", 1'b1, rdy)
    strap(1'b1);
    `CHK("ready after external reset", 1'b0, rdy)
    host.start();
    send(8'hba, 1'b1);
    host.stop();
    host.start();
    send(8'h29, 1'b0);
    recv(8'h00, 1'b1);
    host.stop();
    conclude();
  end
endmodule : tb
`default_nettype wire
